// File: logic/ftsr_map.vh
// register map, field positions, reset values and timing constants
`ifndef FTSR_MAP_VH
`define FTSR_MAP_VH

// ***************************************************
// register offsets
// ***************************************************
`define FTSR_ADDR_TIMER_CTRL   8'h03
`define FTSR_ADDR_POWER_IND    8'h04

// ***************************************************
// safety_timer_flash_control fields
// ***************************************************
`define FTSR_DUR_MSB           7
`define FTSR_DUR_LSB           5
`define FTSR_FAULT_BIT         4
`define FTSR_RANGE_BIT         3
`define FTSR_TRIG_BIT          2
`define FTSR_FLASH_BIT         1
`define FTSR_BLANK_BIT         0
`define FTSR_DUR_RST           3'h6
`define FTSR_RANGE_RST         1'h0
`define FTSR_TRIG_RST          1'h0
`define FTSR_BLANK_EN_RST      1'h1

// ***************************************************
// power_temp_limit_indicator fields
// ***************************************************
`define FTSR_PG_BIT            7
`define FTSR_TEMP_MSB          6
`define FTSR_TEMP_LSB          5
`define FTSR_LIMIT_BIT         4
`define FTSR_IND_MSB           3
`define FTSR_IND_LSB           0
`define FTSR_PG_ROUTE_RST      1'h0
`define FTSR_LIMIT_RST         1'h0
`define FTSR_IND_RST           4'h0
`define FTSR_TEMP_SHUTDOWN     2'h3

// ***************************************************
// operating modes
// ***************************************************
`define FTSR_MODE_SHUTDOWN     2'h0
`define FTSR_MODE_DC_LIGHT     2'h1
`define FTSR_MODE_FLASH        2'h2
`define FTSR_MODE_VOLTAGE      2'h3

// ***************************************************
// timing: clock rate and timer tick
// ***************************************************
`define FTSR_CLK_MHZ           40
`define FTSR_TICK_US           100
`define FTSR_PWM_STEPS         7'h64

// safety durations in units of 0.1 ms, range 0
`define FTSR_R0_T0             32'd682
`define FTSR_R0_T1             32'd1022
`define FTSR_R0_T2             32'd1363
`define FTSR_R0_T3             32'd1704
`define FTSR_R0_T4             32'd2045
`define FTSR_R0_T5             32'd3408
`define FTSR_R0_T6             32'd5793
`define FTSR_R0_T7             32'd8520
// safety durations in units of 0.1 ms, range 1
`define FTSR_R1_T0             32'd53
`define FTSR_R1_T1             32'd107
`define FTSR_R1_T2             32'd160
`define FTSR_R1_T3             32'd213
`define FTSR_R1_T4             32'd266
`define FTSR_R1_T5             32'd320
`define FTSR_R1_T6             32'd373
`define FTSR_R1_T7             32'd715

// indicator pwm duty in percent per code 1000..1111
`define FTSR_DUTY_0            7'h05
`define FTSR_DUTY_1            7'h0b
`define FTSR_DUTY_2            7'h11
`define FTSR_DUTY_3            7'h17
`define FTSR_DUTY_4            7'h1e
`define FTSR_DUTY_5            7'h24
`define FTSR_DUTY_6            7'h2a
`define FTSR_DUTY_7            7'h43

`endif

// File: logic/ftsr_cor_flag.v
// sticky flag cleared after a completed read that returned it set
`timescale 1ns/1ps
module ftsr_cor_flag (
  // clock and reset
  input  wire core_clk,
  input  wire rst_b,
  // event and read handshake
  input  wire set_evt,
  input  wire rd_take,
  input  wire rd_done,
  // state
  output reg  flag_r
);

  reg seen_r;

  // ***************************************************
  // flag and read tracking
  // ***************************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      // an event during the read keeps the flag for the next read
      if (rd_take) begin
        seen_r <= flag_r && !set_evt; // RULE_21
      end else if (rd_done || set_evt) begin
        seen_r <= 1'b0; // RULE_21
      end
      // set wins over the clear
      if (set_evt) begin
        flag_r <= 1'b1;
      end else if (rd_done && seen_r) begin
        flag_r <= 1'b0; // RULE_21
      end
    end
  end

endmodule

// File: logic/ftsr_safety_timer.v
// safety timer: counts a loaded limit while held, flags expiry
`timescale 1ns/1ps
module ftsr_safety_timer (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // control
  input  wire        start,
  input  wire        hold,
  input  wire [31:0] limit,
  // status
  output reg         running_r,
  output reg         timeout_r
);

  reg [31:0] count_r;

  // ***************************************************
  // counter
  // ***************************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r   <= 32'h0;
      running_r <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= 1'b0;
      if (start) begin
        count_r   <= 32'h1;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (!hold) begin
          running_r <= 1'b0;
        end else if (count_r >= limit) begin
          running_r <= 1'b0;
          timeout_r <= 1'b1;
        end else begin
          count_r <= count_r + 32'h1;
        end
      end
    end
  end

endmodule

// File: logic/ftsr_regs.v
// flash timer control and power/indicator status register bank
//
// Functional notes
// [RULE_01] 3-bit safety duration, reset 110, selects one of eight times per range
// [RULE_02] read-only LED fault flag in bit 4, cleared after it is read
// [RULE_03] write-only bit 3 stores timer range 0 or 1
// [RULE_04] read bit 3 is timeout flag, cleared when timer restarts
// [RULE_05] trigger bit: level or rising edge, effective only in flash mode
// [RULE_06] writing 1 to flash start ramps LED only while strobe zero high
// [RULE_07] reading flash start shows whether a flash strobe is ongoing
// [RULE_08] blanking enable (reset 1) reduces LED current while blank input high
// [RULE_09] blanking read flag shows a blanking event, cleared after read
// [RULE_10] route bit picks power good or port value for general pin
// [RULE_11] reading bit 7 returns power good of the converter output
// [RULE_12] die temperature code; 11 after thermal shutdown until read
// [RULE_13] host sets valley limit bit only during initial shutdown
// [RULE_14] valley limit chosen by limit bit and high current select; the code drives valley_limit_hi from the limit bit alone
// [RULE_15] high current select and blank input both high disable power stage
// [RULE_16] indicator codes 0xxx: off or sink currents on privacy pin
// [RULE_17] indicator codes 1xxx: PWM dimming of LED channels, 5% to 67%
// [RULE_18] PWM indicator only in DC-light mode, voltage force set, strobe one low
// [RULE_19] sinking codes pull output node low while high current select low
// [RULE_20] operating mode: shutdown, DC-light, flash, voltage source
// [RULE_21] clear-on-read flags clear only after a completed read that saw them
`timescale 1ns/1ps
`include "ftsr_map.vh"
module ftsr_regs #(
  parameter CYC_PER_TICK = `FTSR_CLK_MHZ * `FTSR_TICK_US
) (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_b,
  // register port from the serial interface engine
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  input  wire       reg_rd_done,
  output wire [7:0] reg_rdata,
  // device state inputs
  input  wire [1:0] op_mode,
  input  wire       voltage_mode_force,
  input  wire       strobe_zero,
  input  wire       strobe_one,
  input  wire       tx_blank,
  input  wire       high_current_select,
  input  wire       led_fault,
  input  wire       power_good,
  input  wire       gpio_port_val,
  input  wire [1:0] die_temp_in,
  input  wire       thermal_shutdown,
  // flash control outputs
  output wire       flash_active,
  output reg        led_current_reduce,
  // power stage outputs
  output reg        gpio_pin_out,
  output reg        valley_limit_hi,
  output reg        power_stage_off,
  // indicator outputs
  output reg  [2:0] privacy_led_pin,
  output reg        output_node_pull,
  output reg        indicator_pwm_on,
  output reg        indicator_pwm_out
);

  // ***************************************************
  // declarations
  // ***************************************************
  reg  [2:0]  safety_duration_sel_r;
  reg         timer_range_sel_r;
  reg         timer_trigger_type_r;
  reg         blank_en_r;
  reg         power_good_route_r;
  reg         valley_limit_sel_r;
  reg  [3:0]  indicator_ctrl_r;
  reg         timeout_flag_r;
  reg         strobe_zero_q_r;
  reg  [7:0]  rdata_r;
  reg  [6:0]  pwm_cnt_r;
  reg  [6:0]  pwm_duty;
  reg  [31:0] dur_tenths;
  reg  [31:0] timer_limit;
  reg  [7:0]  rd_nxt;
  wire        wr_timer;
  wire        wr_power;
  wire        rd_timer;
  wire        rd_power;
  wire        flash_sw_go;
  wire        strobe_rise;
  wire        edge_mode;
  wire        timer_start;
  wire        timer_hold;
  wire        timer_expired;
  wire        blank_event;
  wire        led_fault_flag;
  wire        blank_flag;
  wire        shutdown_flag;
  wire [1:0]  die_temp_code;
  wire        ind_pwm_mode;
  wire        ind_sink_mode;

  // ***************************************************
  // address decode
  // ***************************************************
  assign wr_timer = reg_wr && (reg_addr == `FTSR_ADDR_TIMER_CTRL);
  assign wr_power = reg_wr && (reg_addr == `FTSR_ADDR_POWER_IND);
  assign rd_timer = reg_rd && (reg_addr == `FTSR_ADDR_TIMER_CTRL);
  assign rd_power = reg_rd && (reg_addr == `FTSR_ADDR_POWER_IND);

  // ***************************************************
  // writable control bits
  // ***************************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      safety_duration_sel_r <= `FTSR_DUR_RST;
      timer_range_sel_r     <= `FTSR_RANGE_RST;
      timer_trigger_type_r  <= `FTSR_TRIG_RST;
      blank_en_r            <= `FTSR_BLANK_EN_RST;
      power_good_route_r    <= `FTSR_PG_ROUTE_RST;
      valley_limit_sel_r    <= `FTSR_LIMIT_RST;
      indicator_ctrl_r      <= `FTSR_IND_RST;
    end else begin
      if (wr_timer) begin
        safety_duration_sel_r <=
          reg_wdata[`FTSR_DUR_MSB:`FTSR_DUR_LSB]; // RULE_01
        timer_range_sel_r    <= reg_wdata[`FTSR_RANGE_BIT]; // RULE_03
        timer_trigger_type_r <= reg_wdata[`FTSR_TRIG_BIT]; // RULE_05
        blank_en_r           <= reg_wdata[`FTSR_BLANK_BIT]; // RULE_08
      end
      if (wr_power) begin
        power_good_route_r <= reg_wdata[`FTSR_PG_BIT]; // RULE_10
        indicator_ctrl_r   <=
          reg_wdata[`FTSR_IND_MSB:`FTSR_IND_LSB]; // RULE_16
        // limit changes are taken only while the mode is shutdown
        if (op_mode == `FTSR_MODE_SHUTDOWN) begin
          valley_limit_sel_r <= reg_wdata[`FTSR_LIMIT_BIT]; // RULE_13
        end
      end
    end
  end

  // ***************************************************
  // safety duration lookup
  // ***************************************************
  always @* begin
    dur_tenths = `FTSR_R0_T0;
    case ({timer_range_sel_r, safety_duration_sel_r}) // RULE_01
      4'h0:    dur_tenths = `FTSR_R0_T0;
      4'h1:    dur_tenths = `FTSR_R0_T1;
      4'h2:    dur_tenths = `FTSR_R0_T2;
      4'h3:    dur_tenths = `FTSR_R0_T3;
      4'h4:    dur_tenths = `FTSR_R0_T4;
      4'h5:    dur_tenths = `FTSR_R0_T5;
      4'h6:    dur_tenths = `FTSR_R0_T6;
      4'h7:    dur_tenths = `FTSR_R0_T7;
      4'h8:    dur_tenths = `FTSR_R1_T0;
      4'h9:    dur_tenths = `FTSR_R1_T1;
      4'ha:    dur_tenths = `FTSR_R1_T2;
      4'hb:    dur_tenths = `FTSR_R1_T3;
      4'hc:    dur_tenths = `FTSR_R1_T4;
      4'hd:    dur_tenths = `FTSR_R1_T5;
      4'he:    dur_tenths = `FTSR_R1_T6;
      4'hf:    dur_tenths = `FTSR_R1_T7;
      default: dur_tenths = `FTSR_R0_T0;
    endcase
    timer_limit = dur_tenths * CYC_PER_TICK;
  end

  // ***************************************************
  // flash strobe sequencing
  // ***************************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_zero_q_r <= 1'b0;
    end else begin
      strobe_zero_q_r <= strobe_zero;
    end
  end

  assign strobe_rise = strobe_zero && !strobe_zero_q_r;
  // software start counts only while strobe zero is high
  assign flash_sw_go = wr_timer && reg_wdata[`FTSR_FLASH_BIT]
                       && strobe_zero; // RULE_06
  // edge trigger applies only in flash mode
  assign edge_mode   = timer_trigger_type_r
                       && (op_mode == `FTSR_MODE_FLASH); // RULE_05
  assign timer_start = flash_sw_go
                       || ((op_mode == `FTSR_MODE_FLASH)
                           && strobe_rise); // RULE_20
  assign timer_hold  = edge_mode ? 1'b1 : strobe_zero; // RULE_05

  ftsr_safety_timer u_timer (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .start     (timer_start),
    .hold      (timer_hold),
    .limit     (timer_limit),
    .running_r (flash_active),
    .timeout_r (timer_expired)
  );

  // timeout flag: set on expiry, cleared when the timer restarts
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_flag_r <= 1'b0;
    end else if (timer_expired) begin
      timeout_flag_r <= 1'b1;
    end else if (timer_start) begin
      timeout_flag_r <= 1'b0; // RULE_04
    end
  end

  // ***************************************************
  // clear-on-read flags
  // ***************************************************
  assign blank_event = blank_en_r && tx_blank; // RULE_09

  ftsr_cor_flag u_fault_flag (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_evt  (led_fault),
    .rd_take  (rd_timer),
    .rd_done  (reg_rd_done),
    .flag_r   (led_fault_flag)
  );

  ftsr_cor_flag u_blank_flag (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_evt  (blank_event),
    .rd_take  (rd_timer),
    .rd_done  (reg_rd_done),
    .flag_r   (blank_flag)
  );

  ftsr_cor_flag u_shutdown_flag (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .set_evt  (thermal_shutdown),
    .rd_take  (rd_power),
    .rd_done  (reg_rd_done),
    .flag_r   (shutdown_flag)
  );

  assign die_temp_code = shutdown_flag ? `FTSR_TEMP_SHUTDOWN
                                       : die_temp_in; // RULE_12

  // ***************************************************
  // read data
  // ***************************************************
  always @* begin
    rd_nxt = 8'h00;
    case (reg_addr)
      `FTSR_ADDR_TIMER_CTRL: begin
        rd_nxt[`FTSR_DUR_MSB:`FTSR_DUR_LSB] = safety_duration_sel_r;
        rd_nxt[`FTSR_FAULT_BIT] = led_fault_flag; // RULE_02
        rd_nxt[`FTSR_RANGE_BIT] = timeout_flag_r; // RULE_04
        rd_nxt[`FTSR_TRIG_BIT]  = timer_trigger_type_r;
        rd_nxt[`FTSR_FLASH_BIT] = flash_active; // RULE_07
        rd_nxt[`FTSR_BLANK_BIT] = blank_flag; // RULE_09
      end
      `FTSR_ADDR_POWER_IND: begin
        rd_nxt[`FTSR_PG_BIT] = power_good; // RULE_11
        rd_nxt[`FTSR_TEMP_MSB:`FTSR_TEMP_LSB] = die_temp_code; // RULE_12
        rd_nxt[`FTSR_LIMIT_BIT] = valley_limit_sel_r;
        rd_nxt[`FTSR_IND_MSB:`FTSR_IND_LSB] = indicator_ctrl_r;
      end
      default: rd_nxt = 8'h00;
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ***************************************************
  // indicator pwm
  // ***************************************************
  always @* begin
    pwm_duty = `FTSR_DUTY_0;
    case (indicator_ctrl_r[2:0]) // RULE_17
      3'h0:    pwm_duty = `FTSR_DUTY_0;
      3'h1:    pwm_duty = `FTSR_DUTY_1;
      3'h2:    pwm_duty = `FTSR_DUTY_2;
      3'h3:    pwm_duty = `FTSR_DUTY_3;
      3'h4:    pwm_duty = `FTSR_DUTY_4;
      3'h5:    pwm_duty = `FTSR_DUTY_5;
      3'h6:    pwm_duty = `FTSR_DUTY_6;
      3'h7:    pwm_duty = `FTSR_DUTY_7;
      default: pwm_duty = `FTSR_DUTY_0;
    endcase
  end

  assign ind_pwm_mode  = indicator_ctrl_r[3]
                         && (op_mode == `FTSR_MODE_DC_LIGHT)
                         && voltage_mode_force
                         && !strobe_one; // RULE_18
  // codes x000 and x100 switch the pin off
  assign ind_sink_mode = !indicator_ctrl_r[3]
                         && (indicator_ctrl_r[1:0] != 2'h0); // RULE_16

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt_r <= 7'h00;
    end else if (pwm_cnt_r == `FTSR_PWM_STEPS - 7'h01) begin
      pwm_cnt_r <= 7'h00;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 7'h01;
    end
  end

  // ***************************************************
  // registered outputs
  // ***************************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      led_current_reduce <= 1'b0;
      gpio_pin_out       <= 1'b0;
      valley_limit_hi    <= 1'b0;
      power_stage_off    <= 1'b0;
      privacy_led_pin    <= 3'h0;
      output_node_pull   <= 1'b0;
      indicator_pwm_on   <= 1'b0;
      indicator_pwm_out  <= 1'b0;
    end else begin
      led_current_reduce <= blank_en_r && tx_blank; // RULE_08
      gpio_pin_out       <= power_good_route_r ? gpio_port_val
                                               : power_good; // RULE_10
      valley_limit_hi    <= valley_limit_sel_r; // RULE_14
      power_stage_off    <= high_current_select && tx_blank; // RULE_15
      privacy_led_pin    <= ind_sink_mode ? indicator_ctrl_r[2:0]
                                          : 3'h0; // RULE_16
      output_node_pull   <= ind_sink_mode
                            && !high_current_select; // RULE_19
      indicator_pwm_on   <= ind_pwm_mode; // RULE_18
      indicator_pwm_out  <= ind_pwm_mode
                            && (pwm_cnt_r < pwm_duty); // RULE_17
    end
  end

endmodule

// File: tb/ftsr_regs_assertions.sv
// concurrent checks on the flash timer and status register bank ports
`timescale 1ns/1ps
module ftsr_regs_assertions #(
  parameter CYC_PER_TICK = 4000
) (
  // clock and reset
  input wire       core_clk,
  input wire       rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // device state inputs
  input wire [1:0] op_mode,
  input wire       voltage_mode_force,
  input wire       strobe_zero,
  input wire       strobe_one,
  input wire       tx_blank,
  input wire       high_current_select,
  input wire       power_good,
  // outputs
  input wire       flash_active,
  input wire       led_current_reduce,
  input wire       power_stage_off,
  input wire [2:0] privacy_led_pin,
  input wire       output_node_pull,
  input wire       indicator_pwm_on,
  input wire       indicator_pwm_out
);
  // ********************
  // clocking
  // ********************
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // ********************
  // assertions
  // ********************
  a_stage_off: assert property (
    high_current_select && tx_blank |=> power_stage_off)
    else $error("power stage not disabled");
  a_stage_on: assert property (
    !(high_current_select && tx_blank) |=> !power_stage_off)
    else $error("power stage disabled without cause");
  a_pull_low: assert property (
    output_node_pull |-> privacy_led_pin != 3'h0 &&
    !$past(high_current_select))
    else $error("output node pulled without sink code");
  a_sink_codes: assert property (privacy_led_pin != 3'h4)
    else $error("sink code for an off setting");
  a_pwm_excl: assert property (
    indicator_pwm_on |-> privacy_led_pin == 3'h0)
    else $error("sink active in pwm indicator mode");
  a_pwm_gate: assert property (
    indicator_pwm_on |-> $past(op_mode) == 2'h1 &&
    $past(voltage_mode_force) && !$past(strobe_one))
    else $error("pwm indicator outside its mode");
  a_blank_gate: assert property (
    led_current_reduce |-> $past(tx_blank))
    else $error("current reduced without blank input");
  a_pg_read: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata[7] == $past(power_good))
    else $error("power good read wrong");
  a_flash_strobe: assert property (
    $rose(flash_active) |-> $past(strobe_zero))
    else $error("flash started with strobe zero low");

  // ********************
  // coverage
  // ********************
  c_flash: cover property ($rose(flash_active));
  c_stage_off: cover property (power_stage_off);
  c_pwm: cover property (indicator_pwm_on && indicator_pwm_out);
endmodule

// File: tb/ftsr_host.sv
// host model: register port transfers and camera strobe lines
`timescale 1ns/1ps
module ftsr_host (
  // clock
  input  wire        core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd,
  output logic       reg_rd_done,
  input  wire  [7:0] reg_rdata,
  // strobes
  output logic       strobe_zero,
  output logic       strobe_one
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
    strobe_zero = 1'b0;
    strobe_one = 1'b0;
  end

  // ********************
  // transfers
  // ********************
  // released lines show the inverse so stale data cannot pass
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // read then complete the transaction so flags seen are cleared
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    d = reg_rdata;
    reg_rd_done <= 1'b1;
    @(posedge core_clk);
    reg_rd_done <= 1'b0;
  endtask

  // drive strobe zero and strobe one together on the next clock edge
  task strb(input logic s0, input logic s1);
    @(posedge core_clk);
    strobe_zero <= s0;
    strobe_one <= s1;
  endtask
endmodule

// File: tb/ftsr_regs_bench.sv
// self-checking bench for the flash timer and status register bank
`timescale 1ns/1ps
module ftsr_regs_bench;
  // ********************
  // signals
  // ********************
  logic       core_clk, rst_b, reg_wr, reg_rd, reg_rd_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
  logic [1:0] op_mode, die_temp_in;
  logic       voltage_mode_force, strobe_zero, strobe_one, tx_blank;
  logic       high_current_select, led_fault, power_good, gpio_port_val;
  logic       thermal_shutdown, flash_active, led_current_reduce;
  logic       gpio_pin_out, valley_limit_hi, power_stage_off;
  logic [2:0] privacy_led_pin;
  logic       output_node_pull, indicator_pwm_on, indicator_pwm_out;
  logic [3:0] c;
  logic       snk;
  int         num_errors, checked, hi, k;

  ftsr_regs #(.CYC_PER_TICK(2)) uut (.*);
  ftsr_host host (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ********************
  // tasks
  // ********************
  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk_rd(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_pin(input string nm, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    host.rd(a, rdv);
    chk_rd(nm, e, rdv);
  endtask
  task duty(input logic [3:0] code, input int e);
    host.wr(8'h04, {4'h8, code});
    wt(3);
    hi = 0;
    repeat (100) begin
      @(posedge core_clk);
      hi += indicator_pwm_out;
    end
    chk_rd("pwm duty", e[7:0], hi[7:0]);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(25 * 8000);
    num_errors++;
    end_sim;
  end

  // ********************
  // tests
  // ********************
  initial begin
    {rst_b, op_mode, die_temp_in, voltage_mode_force, tx_blank} = '0;
    {high_current_select, led_fault, power_good, gpio_port_val} = '0;
    thermal_shutdown = 1'b0;
    num_errors = 0;
    checked = 0;
    wt(4);
    rst_b <= 1'b1;
    rdc(8'h03, 8'hc0, "timer reg reset");
    rdc(8'h04, 8'h00, "power reg reset");
    host.wr(8'h05, 8'hff);
    rdc(8'h05, 8'h00, "unmapped read");
    // blanking flag and current reduction
    tx_blank <= 1'b1;
    wt(3);
    chk_pin("reduce on", 3'h1, {2'h0, led_current_reduce});
    tx_blank <= 1'b0;
    wt(3);
    chk_pin("reduce off", 3'h0, {2'h0, led_current_reduce});
    rdc(8'h03, 8'hc1, "blank flag set");
    rdc(8'h03, 8'hc0, "blank flag clear");
    host.wr(8'h03, 8'hc0);
    tx_blank <= 1'b1;
    high_current_select <= 1'b1;
    wt(3);
    chk_pin("reduce off", 3'h0, {2'h0, led_current_reduce});
    chk_pin("stage off", 3'h1, {2'h0, power_stage_off});
    rdc(8'h03, 8'hc0, "blank disabled");
    tx_blank <= 1'b0;
    high_current_select <= 1'b0;
    // led fault flag
    led_fault <= 1'b1;
    wt(1);
    led_fault <= 1'b0;
    // a new fault between read and completion must survive
    fork
      rdc(8'h03, 8'hd0, "fault set");
      begin
        wt(2);
        led_fault <= 1'b1;
        wt(1);
        led_fault <= 1'b0;
      end
    join
    rdc(8'h03, 8'hd0, "fault kept");
    rdc(8'h03, 8'hc0, "fault clear");
    // software flash start
    host.wr(8'h03, 8'h02);
    wt(3);
    chk_pin("no strobe", 3'h0, {2'h0, flash_active});
    host.strb(1'b1, 1'b0);
    host.wr(8'h03, 8'h0a);
    rdc(8'h03, 8'h02, "flash on");
    host.strb(1'b0, 1'b0);
    wt(3);
    rdc(8'h03, 8'h00, "level end");
    // edge trigger runs full range 1 code 000 time: 106 cycles
    op_mode <= 2'h2;
    host.wr(8'h03, 8'h0c);
    host.strb(1'b1, 1'b0);
    wt(90);
    chk_pin("timer run", 3'h1, {2'h0, flash_active});
    wt(30);
    chk_pin("timer end", 3'h0, {2'h0, flash_active});
    rdc(8'h03, 8'h0c, "timeout set");
    host.strb(1'b0, 1'b0);
    host.strb(1'b1, 1'b0);
    wt(4);
    rdc(8'h03, 8'h06, "timeout clear");
    wt(120);
    host.strb(1'b0, 1'b0);
    op_mode <= 2'h0;
    // power good routing and temperature
    power_good <= 1'b1;
    wt(3);
    chk_pin("gpio pg", 3'h1, {2'h0, gpio_pin_out});
    host.wr(8'h04, 8'h80);
    wt(3);
    chk_pin("gpio port", 3'h0, {2'h0, gpio_pin_out});
    die_temp_in <= 2'h1;
    rdc(8'h04, 8'ha0, "temp mid");
    thermal_shutdown <= 1'b1;
    wt(1);
    thermal_shutdown <= 1'b0;
    rdc(8'h04, 8'he0, "temp trip");
    rdc(8'h04, 8'ha0, "temp cleared");
    // valley limit bit only takes in shutdown
    host.wr(8'h04, 8'h90);
    wt(3);
    chk_pin("limit hi", 3'h1, {2'h0, valley_limit_hi});
    op_mode <= 2'h1;
    host.wr(8'h04, 8'h80);
    wt(3);
    chk_pin("limit kept", 3'h1, {2'h0, valley_limit_hi});
    // indicator codes
    voltage_mode_force <= 1'b1;
    for (k = 0; k < 16; k++) begin
      c = k[3:0];
      snk = !c[3] && c[1:0] != 2'h0;
      high_current_select <= c[0] ^ c[3];
      host.wr(8'h04, {4'h8, c});
      wt(3);
      chk_pin("sink", snk ? c[2:0] : 3'h0, privacy_led_pin);
      chk_pin("pull", {2'h0, snk && !(c[0] ^ c[3])},
              {2'h0, output_node_pull});
      chk_pin("pwm on", {2'h0, c[3]}, {2'h0, indicator_pwm_on});
    end
    duty(4'h8, 5);
    duty(4'hf, 67);
    host.strb(1'b0, 1'b1);
    wt(3);
    chk_pin("pwm gated", 3'h0, {2'h0, indicator_pwm_on});
    end_sim;
  end
endmodule

bind ftsr_regs ftsr_regs_assertions #(.CYC_PER_TICK(CYC_PER_TICK)) chk_i (.*);
